// ==== shared/ptb_consts.vh ====
/*
 * Constants for the PWM time base and output pair logic: register byte
 * offsets, field positions, reset values, mode codes and prescale limits.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
// What this block does
// - Four duty generators drive eight outputs grouped as even/odd pairs.
// - A smaller build keeps three generators and six outputs only.
// - In complementary mode the even pin is the inverse of the odd pin.
// - Complementary pairs get a programmable dead time between off and on.
// - Period, duty and event timing comes from a 12-bit counter with prescaler and postscaler.
// - Period and event compare (12-bit) and duties (14-bit) are buffered.
// - The counter runs while the run bit is set, stops when cleared.
// - Clearing the run bit keeps the counter value.
// - Mode field: 00 free, 01 single-shot, 10 up/down, 11 up/down double.
// - Free and single-shot are edge-aligned; up/down modes center-aligned.
// - Prescale field selects input clock divided by 1, 4, 16 or 64.
// - Match events are divided by the postscale field plus one.
// - Duty resolution up to 12 bits, depending on the period; the two duty LSBs round up to a whole count.
// - The up/down double mode signals both ends of a period for updates.
// - A special event compare signals other blocks on a set count.
// - Software may override each output state manually.
// - Outputs are forced inactive while the processor is in debug.
// - Free mode counts up to period, wraps to zero and continues.
// - Single-shot counts to period, wraps to zero and clears the run bit.
// - Up/down reverses after a period match; direction bit set going down.
// - Writes to count or control registers and reset clear the prescaler.
`ifndef PTB_CONSTS_VH
`define PTB_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PTB_OFF_CTRL0    8'h00
`define PTB_OFF_CTRL1    8'h04
`define PTB_OFF_COUNT    8'h08
`define PTB_OFF_PERIOD   8'h0C
`define PTB_OFF_SEVCMP   8'h10
`define PTB_OFF_DUTY0    8'h14
`define PTB_OFF_DEAD     8'h24
`define PTB_OFF_OUTCTL0  8'h28
`define PTB_OFF_OUTCTL1  8'h2C
`define PTB_OFF_OVRSEL   8'h30
`define PTB_OFF_OVRSTATE 8'h34

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PTB_CTRL0_MODE   1:0
`define PTB_CTRL0_PRE    3:2
`define PTB_CTRL0_POST   7:4
`define PTB_CTRL1_RUN    7
`define PTB_CTRL1_DIR    6
`define PTB_OUT1_UPDIS   0
`define PTB_OUT1_DBGOFF  1

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define PTB_CTRL0_RST    8'h00
`define PTB_OUTCTL0_RST  8'h00
`define PTB_PERIOD_RST   12'hFFF
`define PTB_MODE_FREE    2'b00
`define PTB_MODE_SINGLE  2'b01
`define PTB_MODE_UPDN    2'b10
`define PTB_MODE_UPDN2   2'b11
`define PTB_PRE_LIM_1    8'h00
`define PTB_PRE_LIM_4    8'h03
`define PTB_PRE_LIM_16   8'h0F
`define PTB_PRE_LIM_64   8'h3F

`endif

// ==== verilog/ptb_pair.v ====
/*
 * One output pair: complementary or independent drive, dead-time blanking,
 * manual override, debug kill and pin enable.
 * Assumes the raw duty signal is synchronous to hclk.
 */
module ptb_pair
(
	input  wire       hclk,
	input  wire       hresetn,
	input  wire       raw_pwm,
	input  wire       independent,
	input  wire [7:0] dead_cycles,
	input  wire [1:0] ovr_sel,
	input  wire [1:0] ovr_state,
	input  wire       pair_en,
	input  wire       force_off,
	output reg        pin_even,
	output reg        pin_odd
);

	reg       prev_pwm;
	reg [7:0] dead_cnt;
	wire      change;
	wire      blank;
	reg       next_even;
	reg       next_odd;

	assign change = raw_pwm != prev_pwm;
	assign blank  = change ? (dead_cycles != 8'h00) : (dead_cnt != 8'h00);

	// ------------------------------------------------------------------
	// Dead-time counter
	// ------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prev_pwm <= 1'b0;
			dead_cnt <= 8'h00;
		end
		else
		begin
			prev_pwm <= raw_pwm;
			if (change)
				dead_cnt <= (dead_cycles == 8'h00) ? 8'h00 :
					dead_cycles - 8'h01;
			else if (dead_cnt != 8'h00)
				dead_cnt <= dead_cnt - 8'h01;
		end
	end

	// ------------------------------------------------------------------
	// Output selection
	// ------------------------------------------------------------------
	always @*
	begin
		if (independent)
		begin
			next_odd  = raw_pwm;
			next_even = raw_pwm;
		end
		else
		begin
			next_odd  = raw_pwm & ~blank;
			next_even = ~raw_pwm & ~blank;
		end
		if (ovr_sel[0])
			next_even = ovr_state[0];
		if (ovr_sel[1])
			next_odd = ovr_state[1];
		if (force_off || !pair_en)
		begin
			next_even = 1'b0;
			next_odd  = 1'b0;
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_even <= 1'b0;
			pin_odd  <= 1'b0;
		end
		else
		begin
			pin_even <= next_even;
			pin_odd  <= next_odd;
		end
	end

endmodule

// ==== verilog/ptb_top.v ====
/*
 * PWM time base with prescaler, postscaler, four counting modes, buffered
 * period, event compare and duty values, and the output pairs.
 * Assumes hclk is the oscillator divided by four and an AHB-Lite master.
 */
`include "ptb_consts.vh"

module ptb_top
#(
	parameter NUM_GEN = 4,
	parameter CNT_W   = 12,
	parameter DUTY_W  = 14
)
(
	input  wire                 hclk,
	input  wire                 hresetn,
	input  wire                 hsel,
	input  wire [31:0]          haddr,
	input  wire [1:0]           htrans,
	input  wire                 hwrite,
	input  wire [2:0]           hsize,
	input  wire [31:0]          hwdata,
	input  wire                 hready,
	output reg  [31:0]          hrdata,
	output reg                  hreadyout,
	output reg                  hresp,
	input  wire                 debug_halt,
	output wire [2*NUM_GEN-1:0] pwm_out,
	output reg                  period_event,
	output reg                  half_event,
	output reg                  special_event,
	output reg  [CNT_W-1:0]     count_out,
	output reg                  count_down
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg  [7:0]        time_base_control_0;
	reg               time_base_run;
	reg  [CNT_W-1:0]  time_base_count;
	reg  [CNT_W-1:0]  period_buf;
	reg  [CNT_W-1:0]  period_value;
	reg  [CNT_W-1:0]  sev_buf;
	reg  [CNT_W-1:0]  special_event_compare;
	reg  [DUTY_W-1:0] duty_buf [0:NUM_GEN-1];
	reg  [DUTY_W-1:0] duty_act [0:NUM_GEN-1];
	reg  [7:0]        dead_time_control;
	reg  [7:0]        output_control_0;
	reg  [1:0]        output_control_1;
	reg  [7:0]        override_select;
	reg  [7:0]        override_state;

	reg  [7:0]        pre_cnt;
	reg  [3:0]        post_cnt;
	reg  [7:0]        pre_lim;
	reg               dph;
	reg               dph_write;
	reg  [7:0]        dph_addr;
	reg  [31:0]       rd_mux;
	reg  [DUTY_W-1:0] pwm_cmp;
	reg  [NUM_GEN-1:0] raw_pwm;
	integer           i, j, k;

	wire [1:0] mode     = time_base_control_0[`PTB_CTRL0_MODE];
	wire       updown   = mode[1];
	wire       tick     = time_base_run && (pre_cnt == pre_lim);
	wire       at_top   = time_base_count == period_value;
	wire       at_bot   = time_base_count == {CNT_W{1'b0}};
	wire       wr_act   = dph && dph_write;
	wire       wr_ctrl  = wr_act && (dph_addr == `PTB_OFF_CTRL0 ||
		dph_addr == `PTB_OFF_CTRL1);
	wire       wr_count = wr_act && dph_addr == `PTB_OFF_COUNT;
	wire       top_tick = tick && at_top && !(updown && count_down);
	wire       bot_tick = tick && updown && count_down && at_bot;
	wire       match    = updown ? bot_tick : top_tick;
	wire       boundary = match || (mode == `PTB_MODE_UPDN2 && top_tick);
	wire       load_buf = (boundary || !time_base_run) &&
		!output_control_1[`PTB_OUT1_UPDIS];

	// ------------------------------------------------------------------
	// Prescaler limit select
	// ------------------------------------------------------------------
	always @*
	begin
		case (time_base_control_0[`PTB_CTRL0_PRE])
		2'b00:   pre_lim = `PTB_PRE_LIM_1;
		2'b01:   pre_lim = `PTB_PRE_LIM_4;
		2'b10:   pre_lim = `PTB_PRE_LIM_16;
		default: pre_lim = `PTB_PRE_LIM_64;
		endcase
	end

	// ------------------------------------------------------------------
	// AHB-Lite slave: one wait state on every transfer
	// ------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph       <= 1'b0;
			dph_write <= 1'b0;
			dph_addr  <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end
		else if (dph)
		begin
			dph       <= 1'b0;
			hreadyout <= 1'b1;
			if (!dph_write)
				hrdata <= rd_mux;
		end
		else if (hsel && htrans[1] && hready)
		begin
			dph       <= 1'b1;
			dph_write <= hwrite;
			dph_addr  <= haddr[7:0];
			hreadyout <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Read multiplexer; unmapped addresses read zero
	// ------------------------------------------------------------------
	always @*
	begin
		rd_mux = 32'h00000000;
		case (dph_addr)
		`PTB_OFF_CTRL0:    rd_mux[7:0] = time_base_control_0;
		`PTB_OFF_CTRL1:
		begin
			rd_mux[`PTB_CTRL1_RUN] = time_base_run;
			rd_mux[`PTB_CTRL1_DIR] = count_down;
		end
		`PTB_OFF_COUNT:    rd_mux[CNT_W-1:0] = time_base_count;
		`PTB_OFF_PERIOD:   rd_mux[CNT_W-1:0] = period_buf;
		`PTB_OFF_SEVCMP:   rd_mux[CNT_W-1:0] = sev_buf;
		`PTB_OFF_DEAD:     rd_mux[7:0] = dead_time_control;
		`PTB_OFF_OUTCTL0:  rd_mux[7:0] = output_control_0;
		`PTB_OFF_OUTCTL1:  rd_mux[1:0] = output_control_1;
		`PTB_OFF_OVRSEL:   rd_mux[7:0] = override_select;
		`PTB_OFF_OVRSTATE: rd_mux[7:0] = override_state;
		default:
		begin
			for (i = 0; i < NUM_GEN; i = i + 1)
				if (dph_addr == `PTB_OFF_DUTY0 + 4 * i)
					rd_mux[DUTY_W-1:0] = duty_buf[i];
		end
		endcase
	end

	// ------------------------------------------------------------------
	// Configuration registers and buffered values
	// ------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			time_base_control_0   <= `PTB_CTRL0_RST;
			period_buf            <= `PTB_PERIOD_RST;
			period_value          <= `PTB_PERIOD_RST;
			sev_buf               <= {CNT_W{1'b0}};
			special_event_compare <= {CNT_W{1'b0}};
			dead_time_control     <= 8'h00;
			output_control_0      <= `PTB_OUTCTL0_RST;
			output_control_1      <= 2'b00;
			override_select       <= 8'h00;
			override_state        <= 8'h00;
			for (j = 0; j < NUM_GEN; j = j + 1)
			begin
				duty_buf[j] <= {DUTY_W{1'b0}};
				duty_act[j] <= {DUTY_W{1'b0}};
			end
		end
		else
		begin
			if (wr_act)
			begin
				case (dph_addr)
				`PTB_OFF_CTRL0:    time_base_control_0 <= hwdata[7:0];
				`PTB_OFF_PERIOD:   period_buf <= hwdata[CNT_W-1:0];
				`PTB_OFF_SEVCMP:   sev_buf <= hwdata[CNT_W-1:0];
				`PTB_OFF_DEAD:     dead_time_control <= hwdata[7:0];
				`PTB_OFF_OUTCTL0:  output_control_0 <= hwdata[7:0];
				`PTB_OFF_OUTCTL1:  output_control_1 <= hwdata[1:0];
				`PTB_OFF_OVRSEL:   override_select <= hwdata[7:0];
				`PTB_OFF_OVRSTATE: override_state <= hwdata[7:0];
				default:
				begin
					for (j = 0; j < NUM_GEN; j = j + 1)
						if (dph_addr == `PTB_OFF_DUTY0 + 4 * j)
							duty_buf[j] <= hwdata[DUTY_W-1:0];
				end
				endcase
			end
			if (load_buf)
			begin
				period_value          <= period_buf;
				special_event_compare <= sev_buf;
				for (j = 0; j < NUM_GEN; j = j + 1)
					duty_act[j] <= duty_buf[j];
			end
		end
	end

	// ------------------------------------------------------------------
	// Prescaler, counter, direction and run control
	// ------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_cnt         <= 8'h00;
			time_base_count <= {CNT_W{1'b0}};
			count_down      <= 1'b0;
			time_base_run   <= 1'b0;
		end
		else
		begin
			if (wr_count || wr_ctrl || tick || !time_base_run)
				pre_cnt <= 8'h00;
			else
				pre_cnt <= pre_cnt + 8'h01;

			if (wr_count)
				time_base_count <= hwdata[CNT_W-1:0];
			else if (tick)
			begin
				if (!updown)
				begin
					if (at_top)
						time_base_count <= {CNT_W{1'b0}};
					else
						time_base_count <= time_base_count + 1'b1;
				end
				else if (!count_down)
				begin
					if (at_top)
					begin
						count_down <= !at_bot;
						if (!at_bot)
							time_base_count <= time_base_count - 1'b1;
					end
					else
						time_base_count <= time_base_count + 1'b1;
				end
				else if (at_bot)
				begin
					count_down <= 1'b0;
					if (!at_top)
						time_base_count <= time_base_count + 1'b1;
				end
				else
					time_base_count <= time_base_count - 1'b1;
			end
			if (!updown)
				count_down <= 1'b0;

			if (wr_act && dph_addr == `PTB_OFF_CTRL1)
				time_base_run <= hwdata[`PTB_CTRL1_RUN];
			else if (top_tick && mode == `PTB_MODE_SINGLE)
				time_base_run <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Postscaler and event outputs
	// ------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			post_cnt      <= 4'h0;
			period_event  <= 1'b0;
			half_event    <= 1'b0;
			special_event <= 1'b0;
			count_out     <= {CNT_W{1'b0}};
		end
		else
		begin
			period_event  <= 1'b0;
			half_event    <= mode == `PTB_MODE_UPDN2 && top_tick;
			special_event <= tick &&
				time_base_count == special_event_compare;
			count_out     <= time_base_count;
			if (wr_count || wr_ctrl)
				post_cnt <= 4'h0;
			else if (match)
			begin
				if (post_cnt == time_base_control_0[`PTB_CTRL0_POST])
				begin
					post_cnt     <= 4'h0;
					period_event <= 1'b1;
				end
				else
					post_cnt <= post_cnt + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Duty compare: 14-bit duty against count with two fraction bits
	// ------------------------------------------------------------------
	always @*
	begin
		pwm_cmp = {time_base_count, 2'b00};
		for (k = 0; k < NUM_GEN; k = k + 1)
			raw_pwm[k] = duty_act[k] > pwm_cmp;
	end

	// ------------------------------------------------------------------
	// Output pairs
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_GEN; g = g + 1)
		begin : pair
			ptb_pair u_pair
			(
				.hclk        (hclk),
				.hresetn     (hresetn),
				.raw_pwm     (raw_pwm[g]),
				.independent (output_control_0[g]),
				.dead_cycles (dead_time_control),
				.ovr_sel     (override_select[2*g+1:2*g]),
				.ovr_state   (override_state[2*g+1:2*g]),
				.pair_en     (output_control_0[4+g]),
				.force_off   (debug_halt &&
					output_control_1[`PTB_OUT1_DBGOFF]),
				.pin_even    (pwm_out[2*g]),
				.pin_odd     (pwm_out[2*g+1])
			);
		end
	endgenerate

endmodule

// ==== test/ptb_monitor.sv ====
/*
 * Checker for ptb_top: bus wait state and response, pair overlap, counter
 * steps and the top event pulse.
 * Assumes it is bound to ptb_top and given the same parameters.
 */
module ptb_monitor
#(
	parameter NUM_GEN = 4,
	parameter CNT_W   = 12
)
(
	input wire                 hclk,
	input wire                 hresetn,
	input wire                 hsel,
	input wire [1:0]           htrans,
	input wire                 hready,
	input wire [31:0]          hrdata,
	input wire                 hreadyout,
	input wire                 hresp,
	input wire [2*NUM_GEN-1:0] pwm_out,
	input wire                 half_event,
	input wire [CNT_W-1:0]     count_out,
	input wire                 count_down
);
	// ------------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------------
	logic [NUM_GEN-1:0] both_on;

	always_comb
	begin
		for (int g = 0; g < NUM_GEN; g++)
			both_on[g] = pwm_out[2*g] & pwm_out[2*g+1];
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	bus_wait_a: assert property (
		hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
		else $error("bus transfer without exactly one wait state");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	rd_upper_a: assert property (hrdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	pair_overlap_a: assert property (both_on == '0)
		else $error("both pins of a pair active");
	reset_idle_a: assert property ($rose(hresetn) |->
		count_out == '0 && !count_down && pwm_out == '0)
		else $error("outputs not idle after reset");
	count_up_a: assert property (count_out > $past(count_out) |->
		count_out == $past(count_out) + 1'b1)
		else $error("counter rose by more than one");
	count_dn_a: assert property (
		count_out < $past(count_out) && count_out != '0 |->
		count_out == $past(count_out) - 1'b1)
		else $error("counter fell by more than one");
	half_pulse_a: assert property (half_event |=> !half_event)
		else $error("top event longer than one cycle");
endmodule

bind ptb_top ptb_monitor #(.NUM_GEN(NUM_GEN), .CNT_W(CNT_W)) u_monitor
(
	.hclk       (hclk),
	.hresetn    (hresetn),
	.hsel       (hsel),
	.htrans     (htrans),
	.hready     (hready),
	.hrdata     (hrdata),
	.hreadyout  (hreadyout),
	.hresp      (hresp),
	.pwm_out    (pwm_out),
	.half_event (half_event),
	.count_out  (count_out),
	.count_down (count_down)
);

// ==== test/ptb_bridge.sv ====
/*
 * Half-bridge switch model for one output pair: counts shoot-through
 * cycles, turn-ons and the shortest off gap between opposite switches.
 * Assumes gate levels are active high and synchronous to hclk.
 */
module ptb_bridge
(
	input  wire logic hclk,
	input  wire logic gate_hi,
	input  wire logic gate_lo,
	output int        overlap_cycles,
	output int        min_dead,
	output int        hi_turn_ons,
	output int        lo_turn_ons
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prev_hi = 1'b0;
	logic prev_lo = 1'b0;
	logic last_hi = 1'b0;
	int   off_run = 0;

	initial
	begin
		overlap_cycles = 0;
		min_dead = 1000;
		hi_turn_ons = 0;
		lo_turn_ons = 0;
	end

	always @(posedge hclk)
	begin
		if (gate_hi && gate_lo)
			overlap_cycles++;
		if (gate_hi && !prev_hi)
		begin
			hi_turn_ons++;
			if (!last_hi && off_run < min_dead)
				min_dead = off_run;
			last_hi = 1'b1;
		end
		if (gate_lo && !prev_lo)
		begin
			lo_turn_ons++;
			if (last_hi && off_run < min_dead)
				min_dead = off_run;
			last_hi = 1'b0;
		end
		off_run = (gate_hi || gate_lo) ? 0 : off_run + 1;
		prev_hi = gate_hi;
		prev_lo = gate_lo;
	end
endmodule

// ==== test/ptb_top_tb.sv ====
/*
 * Self-checking bench for ptb_top: register access, counting modes,
 * prescale and postscale spacing, run control, pair outputs and debug.
 * Assumes the bench is the only bus master and hready is hreadyout.
 */
`include "ptb_consts.vh"
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
	failures++; $display("wrong value %s exp %0h got %0h", what, exp, got); \
	end end

module ptb_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] ctrl; logic [11:0] per; int gap;
		logic dn; logic hf;} ptb_row_t;
	logic        hclk, hresetn, hsel, hwrite, debug_halt, dn, hf;
	logic [31:0] haddr, hwdata, r, a;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, hready, period_event, half_event;
	wire         special_event, count_down;
	wire  [7:0]  pwm_out;
	wire  [11:0] count_out;
	int          failures, checks, gap, overlap, min_dead, hi_on, lo_on;
	int          sev_seen, s0;
	ptb_row_t    rows [7] = '{'{8'h00, 12'h005, 6, 1'b0, 1'b0},
		'{8'h04, 12'h003, 16, 1'b0, 1'b0}, '{8'h18, 12'h002, 96, 1'b0, 1'b0},
		'{8'h0C, 12'h001, 128, 1'b0, 1'b0}, '{8'hF0, 12'h001, 32, 1'b0, 1'b0},
		'{8'h22, 12'h005, 30, 1'b1, 1'b0}, '{8'h33, 12'h004, 32, 1'b1, 1'b1}};

	assign hready = hreadyout;

	always @(posedge hclk)
		if (special_event === 1'b1)
			sev_seen++;

	ptb_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .debug_halt(debug_halt), .pwm_out(pwm_out),
		.period_event(period_event), .half_event(half_event),
		.special_event(special_event), .count_out(count_out),
		.count_down(count_down));

	ptb_bridge bridge (.hclk(hclk), .gate_hi(pwm_out[1]),
		.gate_lo(pwm_out[0]), .overlap_cycles(overlap), .min_dead(min_dead),
		.hi_turn_ons(hi_on), .lo_turn_ons(lo_on));

	// ------------------------------------------------------------------
	// Bus and measurement tasks
	// ------------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [31:0] wd, output logic [31:0] rd);
	begin
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, ad};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] unused;
		bus(1'b1, ad, d, unused);
	endtask

	// Spacing in cycles between two postscaled match events.
	task automatic measure();
	begin
		gap = 0;
		dn = 1'b0;
		hf = 1'b0;
		@(posedge hclk);
		while (period_event !== 1'b1) @(posedge hclk);
		do
		begin
			@(posedge hclk);
			gap++;
			dn |= count_down;
			hf |= half_event;
		end
		while (period_event !== 1'b1);
	end
	endtask

	task automatic tally_and_finish();
	begin
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask

	// ------------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ------------------------------------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	initial
	begin
		#200000;
		failures++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial
	begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, debug_halt} = '0;
		hsize = 3'b010;
		failures = 0;
		checks = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, `PTB_OFF_CTRL0, 32'h0, r);
		`CHK("ctrl0 reset", 32'h00000000, r)
		wr(`PTB_OFF_CTRL1, 32'h00000040);
		bus(1'b0, `PTB_OFF_CTRL1, 32'h0, r);
		`CHK("direction read only", 32'h00000000, r)
		wr(8'hFC, 32'hFFFFFFFF);
		bus(1'b0, 8'hFC, 32'h0, r);
		`CHK("unmapped read", 32'h00000000, r)
		foreach (rows[i])
		begin
			wr(`PTB_OFF_CTRL1, 32'h00000000);
			wr(`PTB_OFF_COUNT, 32'h00000000);
			wr(`PTB_OFF_CTRL0, {24'h000000, rows[i].ctrl});
			wr(`PTB_OFF_PERIOD, {20'h00000, rows[i].per});
			wr(`PTB_OFF_CTRL1, 32'h00000080);
			measure();
			`CHK("event spacing", rows[i].gap, gap)
			`CHK("down seen", rows[i].dn, dn)
			`CHK("top event seen", rows[i].hf, hf)
		end
		wr(`PTB_OFF_CTRL1, 32'h00000000);
		wr(`PTB_OFF_CTRL0, 32'h00000000);
		wr(`PTB_OFF_PERIOD, 32'h000000C8);
		wr(`PTB_OFF_CTRL1, 32'h00000080);
		repeat (30) @(posedge hclk);
		wr(`PTB_OFF_CTRL1, 32'h00000000);
		bus(1'b0, `PTB_OFF_COUNT, 32'h0, a);
		repeat (10) @(posedge hclk);
		bus(1'b0, `PTB_OFF_COUNT, 32'h0, r);
		`CHK("count held", a, r)
		`CHK("count advanced", 1'b1, a !== 32'h0)
		wr(`PTB_OFF_COUNT, 32'h00000000);
		wr(`PTB_OFF_CTRL0, 32'h00000001);
		wr(`PTB_OFF_PERIOD, 32'h0000000A);
		wr(`PTB_OFF_CTRL1, 32'h00000080);
		repeat (40) @(posedge hclk);
		bus(1'b0, `PTB_OFF_CTRL1, 32'h0, r);
		`CHK("single shot stop", 32'h00000000, r)
		bus(1'b0, `PTB_OFF_COUNT, 32'h0, r);
		`CHK("single shot count", 32'h00000000, r)
		wr(`PTB_OFF_CTRL0, 32'h00000000);
		wr(`PTB_OFF_PERIOD, 32'h00000014);
		wr(`PTB_OFF_DUTY0, 32'h00000028);
		wr(`PTB_OFF_DEAD, 32'h00000003);
		wr(`PTB_OFF_OUTCTL0, 32'h000000F0);
		wr(`PTB_OFF_SEVCMP, 32'h00000005);
		wr(`PTB_OFF_CTRL1, 32'h00000080);
		s0 = sev_seen;
		repeat (200) @(posedge hclk);
		`CHK("special events", 10, sev_seen - s0)
		`CHK("shoot through", 0, overlap)
		`CHK("dead gap", 1'b1, min_dead >= 3)
		`CHK("odd switching", 1'b1, hi_on > 2)
		`CHK("even switching", 1'b1, lo_on > 2)
		wr(`PTB_OFF_OUTCTL1, 32'h00000002);
		debug_halt <= 1'b1;
		repeat (4) @(posedge hclk);
		`CHK("debug force off", 8'h00, pwm_out)
		debug_halt <= 1'b0;
		repeat (30) @(posedge hclk);
		`CHK("debug release", 1'b1, pwm_out !== 8'h00)
		wr(`PTB_OFF_OVRSTATE, 32'h00000001);
		wr(`PTB_OFF_OVRSEL, 32'h00000003);
		repeat (2) @(posedge hclk);
		`CHK("override pins", 2'b01, pwm_out[1:0])
		wr(`PTB_OFF_CTRL0, 32'h000000F0);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK("reset pins", 8'h00, pwm_out)
		bus(1'b0, `PTB_OFF_CTRL0, 32'h0, r);
		`CHK("ctrl0 after reset", 32'h00000000, r)
		tally_and_finish();
	end
endmodule
